// ---- apg_pkg.sv ----
// package for the record gain amplifier and third-mic mix control registers
package apg_pkg;
  // register offsets on the codec register port
  localparam logic [6:0] APG_ADDR_LEFT_GAIN = 7'h0F;
  localparam logic [6:0] APG_ADDR_RIGHT_GAIN = 7'h10;
  localparam logic [6:0] APG_ADDR_MIX_LEFT = 7'h11;
  localparam logic [6:0] APG_ADDR_MIX_RIGHT = 7'h12;
  // field positions
  localparam int APG_MUTE_BIT = 7;
  localparam int APG_GAIN_LSB = 0;
  localparam int APG_GAIN_W = 7;
  localparam int APG_LVL_HI_LSB = 4;
  localparam int APG_LVL_LO_LSB = 0;
  localparam int APG_LVL_W = 4;
  // reset values
  localparam logic [7:0] APG_GAIN_RST = 8'h80;
  localparam logic [7:0] APG_MIX_RST = 8'hFF;
  // gain saturates at code 0x77 (59.5 dB in 0.5 dB steps)
  localparam logic [6:0] APG_GAIN_SAT = 7'h77;
  // level codes: 0x0..0x8 attenuate 1.5 dB per step, 0xF disconnects
  localparam logic [3:0] APG_LVL_MAX_VALID = 4'h8;
  localparam logic [3:0] APG_LVL_OFF = 4'hF;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } apg_req_t;

  // one input-to-mix path as seen by the analog mixer
  typedef struct packed {
    logic connect;
    logic [3:0] atten;
  } apg_mix_path_t;

  // one record channel as seen by the analog gain stage
  typedef struct packed {
    logic mute;
    logic [6:0] gain_half_db;
  } apg_chan_t;
endpackage

// ---- apg_regs.sv ----
// record gain amplifier and third-mic mix control register bank
//
// Functional notes
// - left record gain amplifier mute is bit 7, resets to 1 (muted)
// - right record gain amplifier mute is bit 7, resets to 1 (muted)
// - left gain is bits 6..0, resets 0 (0 dB), 0.5 dB per code
// - right gain is bits 6..0, resets 0 (0 dB), 0.5 dB per code
// - gain codes 0x77 and above all give 59.5 dB
// - left third-mic into left mix: upper nibble, resets 1111
// - right third-mic into left mix: lower nibble, resets 1111
// - left third-mic into right mix: upper nibble, resets 1111
// - right third-mic into right mix: lower nibble, resets 1111
// - level code 0 is 0 dB, code 8 is -12 dB, 1.5 dB per step
// - a valid level code connects the input to that mix by itself
// - level code 1111 leaves the input disconnected
`timescale 1ns/1ps
module apg_regs
  import apg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port from the control bus engine
  input apg_pkg::apg_req_t req,
  output logic [7:0] rdata_r,
  output logic rvalid_r,
  // controls to the left and right record gain amplifiers
  output apg_pkg::apg_chan_t left_chan_r,
  output apg_pkg::apg_chan_t right_chan_r,
  // third-mic paths into the left mix
  output apg_pkg::apg_mix_path_t third_mic_left_input_to_left_r,
  output apg_pkg::apg_mix_path_t third_mic_right_input_to_left_r,
  // third-mic paths into the right mix
  output apg_pkg::apg_mix_path_t third_mic_left_input_to_right_r,
  output apg_pkg::apg_mix_path_t third_mic_right_input_to_right_r
);
  import apg_pkg::*;

  // reset images of the decoded controls, built from the package gain reset value and the maximum valid level code
  localparam apg_chan_t CHAN_RST = APG_GAIN_RST;
  localparam apg_mix_path_t PATH_RST = '{connect: 1'b0, atten: APG_LVL_MAX_VALID};

  // stored images, read back exactly as written, reserved codes included
  logic [7:0] left_gain_r;
  logic [7:0] right_gain_r;
  logic [7:0] mix_left_r;
  logic [7:0] mix_right_r;

  // one select per mapped offset
  logic sel_left_gain;
  logic sel_right_gain;
  logic sel_mix_left;
  logic sel_mix_right;

  logic [7:0] rdata_nxt;
  apg_chan_t left_chan_nxt;
  apg_chan_t right_chan_nxt;
  apg_mix_path_t third_mic_left_input_to_left_nxt;
  apg_mix_path_t third_mic_right_input_to_left_nxt;
  apg_mix_path_t third_mic_left_input_to_right_nxt;
  apg_mix_path_t third_mic_right_input_to_right_nxt;

  // true when the request addresses the given offset
  function automatic logic addr_is(input logic [6:0] addr, input logic [6:0] offset);
    addr_is = (addr == offset);
  endfunction

  // saturating gain, value counts half-dB steps
  function automatic logic [6:0] sat_gain(input logic [6:0] code);
    sat_gain = (code > APG_GAIN_SAT) ? APG_GAIN_SAT : code;
  endfunction

  // mute passes through; the gain field saturates for the analog stage
  function automatic apg_chan_t chan_decode(input logic [7:0] value);
    chan_decode.mute = value[APG_MUTE_BIT];
    chan_decode.gain_half_db = sat_gain(value[APG_GAIN_LSB +: APG_GAIN_W]);
  endfunction

  // reserved codes are treated as disconnected so a stray write cannot add an unknown level
  function automatic apg_mix_path_t lvl_decode(input logic [3:0] code);
    lvl_decode.connect = (code <= APG_LVL_MAX_VALID);
    lvl_decode.atten = (code <= APG_LVL_MAX_VALID) ? code : APG_LVL_MAX_VALID;
  endfunction

  // address decode, shared by the write and read paths
  always_comb begin
    sel_left_gain = addr_is(req.addr, APG_ADDR_LEFT_GAIN);
    sel_right_gain = addr_is(req.addr, APG_ADDR_RIGHT_GAIN);
    sel_mix_left = addr_is(req.addr, APG_ADDR_MIX_LEFT);
    sel_mix_right = addr_is(req.addr, APG_ADDR_MIX_RIGHT);
  end

  // left gain register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left_gain_r <= APG_GAIN_RST;
    end else if (req.wr && sel_left_gain) begin
      left_gain_r <= req.wdata;
    end
  end

  // right gain register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      right_gain_r <= APG_GAIN_RST;
    end else if (req.wr && sel_right_gain) begin
      right_gain_r <= req.wdata;
    end
  end

  // third-mic levels into the left mix
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mix_left_r <= APG_MIX_RST;
    end else if (req.wr && sel_mix_left) begin
      mix_left_r <= req.wdata;
    end
  end

  // third-mic levels into the right mix
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mix_right_r <= APG_MIX_RST;
    end else if (req.wr && sel_mix_right) begin
      mix_right_r <= req.wdata;
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (sel_left_gain) begin
      rdata_nxt = left_gain_r;
    end
    if (sel_right_gain) begin
      rdata_nxt = right_gain_r;
    end
    if (sel_mix_left) begin
      rdata_nxt = mix_left_r;
    end
    if (sel_mix_right) begin
      rdata_nxt = mix_right_r;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (req.rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  // read valid pulses for one cycle after each read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= req.rd;
    end
  end

  // channel decode; outputs lag the registers by one cycle
  always_comb begin
    left_chan_nxt = chan_decode(left_gain_r);
    right_chan_nxt = chan_decode(right_gain_r);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      left_chan_r <= CHAN_RST;
    end else begin
      left_chan_r <= left_chan_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      right_chan_r <= CHAN_RST;
    end else begin
      right_chan_r <= right_chan_nxt;
    end
  end

  // level decode; outputs lag the registers by one cycle
  always_comb begin
    third_mic_left_input_to_left_nxt = lvl_decode(mix_left_r[APG_LVL_HI_LSB +: APG_LVL_W]);
    third_mic_right_input_to_left_nxt = lvl_decode(mix_left_r[APG_LVL_LO_LSB +: APG_LVL_W]);
    third_mic_left_input_to_right_nxt = lvl_decode(mix_right_r[APG_LVL_HI_LSB +: APG_LVL_W]);
    third_mic_right_input_to_right_nxt = lvl_decode(mix_right_r[APG_LVL_LO_LSB +: APG_LVL_W]);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      third_mic_left_input_to_left_r <= PATH_RST;
    end else begin
      third_mic_left_input_to_left_r <= third_mic_left_input_to_left_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      third_mic_right_input_to_left_r <= PATH_RST;
    end else begin
      third_mic_right_input_to_left_r <= third_mic_right_input_to_left_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      third_mic_left_input_to_right_r <= PATH_RST;
    end else begin
      third_mic_left_input_to_right_r <= third_mic_left_input_to_right_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      third_mic_right_input_to_right_r <= PATH_RST;
    end else begin
      third_mic_right_input_to_right_r <= third_mic_right_input_to_right_nxt;
    end
  end
endmodule

// ---- apg_regs_chk.sv ----
// assertion checker for the record gain register bank
`timescale 1ns/1ps
module apg_regs_chk
  import apg_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port and channel controls
  input apg_pkg::apg_req_t req,
  input wire logic [7:0] rdata_r,
  input wire logic rvalid_r,
  input apg_pkg::apg_chan_t left_chan_r,
  input apg_pkg::apg_chan_t right_chan_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic [7:0] wd = req.wdata;
  wire logic [6:0] a = req.addr;
  wire logic hit = a inside {[7'h0F:7'h12]};
  function automatic apg_chan_t ch(logic [7:0] v);
    return {v[7], v[6:0] > APG_GAIN_SAT ? APG_GAIN_SAT : v[6:0]};
  endfunction
  a_read_answer: assert property (req.rd |=> rvalid_r)
    else $error("read unanswered");
  a_read_quiet: assert property (!req.rd |=> !rvalid_r && $stable(rdata_r))
    else $error("read data moved");
  a_unmapped_zero: assert property (req.rd && !hit |=> rdata_r == 8'h00)
    else $error("unmapped read nonzero");
  a_unmapped_keep: assert property (req.wr && !hit |=> ##1 $stable(left_chan_r))
    else $error("unmapped write changed state");
  a_reset_muted: assert property ($rose(resetn) |-> {left_chan_r, right_chan_r} == 16'h8080)
    else $error("reset state wrong");
  a_left_chan: assert property (req.wr && a == APG_ADDR_LEFT_GAIN
    |=> ##1 left_chan_r == ch($past(wd, 2))) else $error("left channel wrong");
  a_right_chan: assert property (req.wr && a == APG_ADDR_RIGHT_GAIN
    |=> ##1 right_chan_r == ch($past(wd, 2))) else $error("right channel wrong");
  a_gain_ceiling: assert property (right_chan_r.gain_half_db <= 7'h77)
    else $error("gain above ceiling");
endmodule
bind apg_regs apg_regs_chk i_chk (.clk_sys, .resetn, .req, .rdata_r, .rvalid_r, .left_chan_r,
  .right_chan_r);

// ---- test_apg_regs.sv ----
// self-checking testbench for the record gain register bank
`timescale 1ns/1ps
module test_apg_regs;
  import apg_pkg::*;
  logic clk_sys = 0;
  logic resetn = 0;
  apg_req_t req = '0;
  logic [7:0] rdata_r, m[4], d;
  logic [6:0] a;
  logic rvalid_r;
  apg_chan_t lc, rc;
  apg_mix_path_t ml, mr, nl, nr;
  int n_mismatch = 0, tests_run = 0, cyc = 0, i;
  logic [7:0] bv[8] = '{8'h76, 8'hF7, 8'h78, 8'h7F, 8'h08, 8'h80, 8'h00, 8'h8F};
  apg_regs i_dut (.clk_sys, .resetn, .req, .rdata_r, .rvalid_r, .left_chan_r(lc),
    .right_chan_r(rc), .third_mic_left_input_to_left_r(ml),
    .third_mic_right_input_to_left_r(mr), .third_mic_left_input_to_right_r(nl),
    .third_mic_right_input_to_right_r(nr));
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      final_report();
    end
  end
  function automatic logic [7:0] ch(logic [7:0] v);
    return {v[7], v[6:0] > 7'h77 ? 7'h77 : v[6:0]};
  endfunction
  // reserved codes are never written, so only 0..8 and 1111 reach the mixer
  function automatic logic [4:0] mx(logic [3:0] c);
    return c <= 4'h8 ? {1'b1, c} : 5'h08;
  endfunction
  function automatic logic [3:0] nb();
    int r = $urandom % 10;
    return r == 9 ? 4'hF : 4'(r);
  endfunction
  task automatic chk(string n, logic [35:0] s, logic [35:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic go(logic w, logic [6:0] ad, logic [7:0] dv);
    logic hit;
    logic [35:0] e;
    hit = ad inside {[7'h0F:7'h12]};
    @(negedge clk_sys);
    req = '{wr: w, rd: !w, addr: ad, wdata: dv};
    @(negedge clk_sys);
    if (!w) chk("rdata", {rvalid_r, rdata_r}, {1'b1, hit ? m[ad - 7'h0F] : 8'h00});
    req = '0;
    if (w && hit) m[ad - 7'h0F] = dv;
    @(negedge clk_sys);
    e = {ch(m[0]), ch(m[1]), mx(m[2][7:4]), mx(m[2][3:0]), mx(m[3][7:4]), mx(m[3][3:0])};
    chk("outputs", {lc, rc, ml, mr, nl, nr}, e);
  endtask
  task automatic rst();
    resetn = 0;
    m = '{8'h80, 8'h80, 8'hFF, 8'hFF};
    repeat (3) @(negedge clk_sys);
    resetn = 1;
    for (i = 14; i < 20; i++) go(0, 7'(i), 8'h00);
    $display("reset test done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    i = $urandom(93);
    rst();
    for (i = 0; i < 8; i++) go(1, 7'h0F + 7'(i % 4), bv[i]);
    for (i = 0; i < 4; i++) go(0, 7'h0F + 7'(i), 8'h00);
    $display("boundary test done");
    repeat (60) begin
      a = 7'h0E + 7'($urandom % 6);
      d = a > 7'h10 ? {nb(), nb()} : 8'($urandom);
      go(1'($urandom), a, d);
    end
    $display("random test done");
    rst();
    final_report();
  end
endmodule
